//--- verilog/dsh_slope_ctrl.sv
// Slope, triangle and hysteretic waveform control for one DAC channel.
`timescale 1ns/10ps
`include "dsh_params.svh"
// What this block does
// RULE1: Slope enable runs the ramp; clearing it stops and zeroes the accumulator.
// RULE2: Hysteretic enable switches the channel into hysteretic mode.
// RULE3: Triangle enable makes the ramp bounce between the two limits.
// RULE4: Direction bit set ramps upward, clear ramps downward.
// RULE5: Software keeps slope enable clear while using hysteretic mode.
// RULE6: Software sets slope enable whenever triangle mode is used.
// RULE7: Selected hysteretic input picks high or low limit as DAC data.
// RULE8: Selected hysteretic input also sets the comparator polarity.
// RULE9: Both edges of the hysteretic input restart the blanking counter.
// RULE10: Hysteretic code 1111 is one, 0000 zero, others pick PWM high sides. The code picks inputs for 1..12 only and gives zero for 13 and 14.
// RULE11: Stop A OR stop B terminates the running slope.
// RULE12: Stop A code 1111 is one, 0000 zero, others pick PWM triggers. The code picks triggers for 1..8, 13 and 14 only and gives zero for 9..12.
// RULE13: Stop B code 1111 is one, 0000 zero, 1..4 pick comparator outputs.
// RULE14: Start field picks the signal whose rising edge begins a slope.
// RULE15: Ramp rate is unsigned 12.4 fixed point.
// RULE16: Ramp rate is held left justified in its 16-bit word.
// RULE17: Ten-bit blanking count sets the comparator mask time after switching.
// RULE18: Software keeps both limit values within 205 to 3890.
// RULE19: Running ramp steps by the rate each clock and holds on stop.
module dsh_slope_ctrl
  import dsh_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [`DSH_HYST_W-1:0] hyst_src,
  input wire logic [`DSH_TRIG_W-1:0] stop_a_src,
  input wire logic [`DSH_CMP_W-1:0] stop_b_src,
  input wire logic [`DSH_TRIG_W-1:0] start_src,
  output logic [11:0] dac_data,
  output logic cmp_invert,
  output logic cmp_blank,
  output logic ramp_active
);
  logic [15:0] conh_reg;
  logic [15:0] conl_reg;
  logic [15:0] rate_reg;
  logic [11:0] high_reg;
  logic [11:0] low_reg;
  logic [9:0] blank_cfg_reg;
  logic [15:0] rd_data_reg;
  logic [`DSH_SYNC_W-1:0] sync1_reg;
  logic [`DSH_SYNC_W-1:0] sync2_reg;
  dsh_state_t state_reg;
  dsh_state_t state_next;
  logic [15:0] acc_reg;
  logic [15:0] acc_next;
  logic dir_up_reg;
  logic dir_up_next;
  logic start_prev_reg;
  logic hyst_prev_reg;
  logic [9:0] blank_cnt_reg;
  logic [9:0] blank_cnt_next;
  logic blank_reg;
  logic invert_reg;
  logic [11:0] dac_reg;
  logic active_reg;

  dsh_sel_if sel_bus ();

  dsh_source_select u_select (
    .sel(sel_bus)
  );

  // Register decode and the read mux; the fall-through read gives the accumulator.
  wire wr_conh = reg_wr && (reg_addr == `DSH_OFS_CONH);
  wire wr_conl = reg_wr && (reg_addr == `DSH_OFS_CONL);
  wire wr_rate = reg_wr && (reg_addr == `DSH_OFS_RATE);
  wire wr_high = reg_wr && (reg_addr == `DSH_OFS_HIGH);
  wire wr_low = reg_wr && (reg_addr == `DSH_OFS_LOW);
  wire wr_blank = reg_wr && (reg_addr == `DSH_OFS_BLANK);
  wire [15:0] status_word = {12'h000, dir_up_reg, blank_reg, sel_bus.hyst_level, active_reg};
  wire [15:0] rd_mux =
    (reg_addr == `DSH_OFS_CONH) ? conh_reg :
    (reg_addr == `DSH_OFS_CONL) ? conl_reg :
    (reg_addr == `DSH_OFS_RATE) ? rate_reg :
    (reg_addr == `DSH_OFS_HIGH) ? {4'h0, high_reg} :
    (reg_addr == `DSH_OFS_LOW) ? {4'h0, low_reg} :
    (reg_addr == `DSH_OFS_BLANK) ? {6'h00, blank_cfg_reg} :
    (reg_addr == `DSH_OFS_STAT) ? status_word : acc_reg;

  // Software registers; unimplemented control bits are masked so they read zero.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      conh_reg <= `DSH_RST_16;
      conl_reg <= `DSH_RST_16;
      rate_reg <= `DSH_RST_16;
      high_reg <= `DSH_RST_12;
      low_reg <= `DSH_RST_12;
      blank_cfg_reg <= `DSH_RST_10;
    end else begin
      if (wr_conh) conh_reg <= reg_wdata & `DSH_CONH_MASK;
      if (wr_conl) conl_reg <= reg_wdata;
      // RULE16: stored left justified
      if (wr_rate) rate_reg <= reg_wdata;
      if (wr_high) high_reg <= reg_wdata[11:0];
      if (wr_low) low_reg <= reg_wdata[11:0];
      if (wr_blank) blank_cfg_reg <= reg_wdata[9:0];
    end
  end

  // Read data stand for exactly one cycle after the strobe.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) rd_data_reg <= `DSH_RST_16;
    else rd_data_reg <= reg_rd ? rd_mux : `DSH_RST_16;
  end

  // Two-flop synchroniser for every pin-level source; only stage two is read.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {hyst_src, stop_a_src, stop_b_src, start_src};
      sync2_reg <= sync1_reg;
    end
  end

  // Field routing into the selector.
  assign sel_bus.hyst_code = conl_reg[15:12];
  assign sel_bus.stop_a_code = conl_reg[11:8];
  assign sel_bus.stop_b_code = conl_reg[7:4];
  assign sel_bus.start_code = conl_reg[3:0];
  assign sel_bus.hyst_vec = sync2_reg[35:24];
  assign sel_bus.stop_a_vec = sync2_reg[23:14];
  assign sel_bus.stop_b_vec = sync2_reg[13:10];
  assign sel_bus.start_vec = sync2_reg[9:0];

  // Mode decode.
  wire ramp_on = conh_reg[`DSH_BIT_RAMP_ON];
  wire tri_on = conh_reg[`DSH_BIT_TRI_ON];
  wire positive = conh_reg[`DSH_BIT_POSITIVE];
  // RULE2: hysteretic mode gate
  // RULE5: hysteresis only without slope
  wire hyst_mode = conh_reg[`DSH_BIT_HYST_ON] && !ramp_on;
  // RULE6: triangle needs slope enable
  wire tri_mode = tri_on && ramp_on;
  // RULE11: stops are ORed
  wire stop_any = sel_bus.stop_a || sel_bus.stop_b;
  wire start_edge = sel_bus.start_level && !start_prev_reg;
  wire hyst_edge = sel_bus.hyst_level != hyst_prev_reg;

  // RULE15: limits widened into 12.4 to match the rate.
  wire [15:0] high_fx = {high_reg, `DSH_FRAC_ZERO};
  wire [15:0] low_fx = {low_reg, `DSH_FRAC_ZERO};
  // Limit hits are found by distance, so no sum can wrap past 16 bits.
  wire up_hit = (acc_reg >= high_fx) || ((high_fx - acc_reg) <= rate_reg);
  wire dn_hit = (acc_reg <= low_fx) || ((acc_reg - low_fx) <= rate_reg);

  // Ramp sequencer: start edge loads, each clock steps, stop holds, a limit holds or in triangle mode turns.
  always_comb begin
    state_next = state_reg;
    acc_next = acc_reg;
    dir_up_next = dir_up_reg;
    if (!ramp_on) begin
      // RULE1: accumulator off
      state_next = DSH_IDLE;
      acc_next = `DSH_RST_16;
    end else begin
      unique case (state_reg)
        DSH_IDLE, DSH_HOLD: begin
          // RULE14: start edge begins
          if (start_edge && !stop_any) begin
            state_next = DSH_RAMP;
            // RULE4: direction picks start
            dir_up_next = positive;
            acc_next = positive ? low_fx : high_fx;
          end
        end
        DSH_RAMP: begin
          if (stop_any) begin
            // RULE19: hold on stop
            state_next = DSH_HOLD;
          end else if (dir_up_reg) begin
            // RULE19: step by rate
            acc_next = up_hit ? high_fx : acc_reg + rate_reg;
            // RULE3: bounce at top
            if (up_hit && tri_mode) dir_up_next = 1'b0;
            else if (up_hit) state_next = DSH_HOLD;
          end else begin
            acc_next = dn_hit ? low_fx : acc_reg - rate_reg;
            if (dn_hit && tri_mode) dir_up_next = 1'b1;
            else if (dn_hit) state_next = DSH_HOLD;
          end
        end
        default: state_next = DSH_IDLE;
      endcase
    end
  end

  // RULE9: restart on either edge
  assign blank_cnt_next = (hyst_mode && hyst_edge) ? blank_cfg_reg :
    (blank_cnt_reg != `DSH_RST_10) ? blank_cnt_reg - 10'h001 : `DSH_RST_10;

  // Sequencer and edge-history state.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= DSH_IDLE;
      acc_reg <= `DSH_RST_16;
      dir_up_reg <= 1'b0;
      start_prev_reg <= 1'b0;
      hyst_prev_reg <= 1'b0;
      blank_cnt_reg <= `DSH_RST_10;
    end else begin
      state_reg <= state_next;
      acc_reg <= acc_next;
      dir_up_reg <= dir_up_next;
      // Cleared while the slope is off, so a constant-one start fires once on enable.
      start_prev_reg <= ramp_on ? sel_bus.start_level : 1'b0;
      hyst_prev_reg <= sel_bus.hyst_level;
      blank_cnt_reg <= blank_cnt_next;
    end
  end

  // Output flops; the DAC sees the limit pair in hysteretic mode, else the ramp.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dac_reg <= `DSH_RST_12;
      invert_reg <= 1'b0;
      blank_reg <= 1'b0;
      active_reg <= 1'b0;
    end else begin
      // RULE7: limit switching
      dac_reg <= hyst_mode ? (sel_bus.hyst_level ? high_reg : low_reg) : acc_next[15:4];
      // RULE8: polarity follows input
      invert_reg <= hyst_mode && sel_bus.hyst_level;
      // RULE17: mask while counting
      blank_reg <= blank_cnt_next != `DSH_RST_10;
      active_reg <= state_next == DSH_RAMP;
    end
  end

  assign reg_rdata = rd_data_reg;
  assign dac_data = dac_reg;
  assign cmp_invert = invert_reg;
  assign cmp_blank = blank_reg;
  assign ramp_active = active_reg;

  default clocking dsh_cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Checks on the control behaviour.
  AST_OFF_ZERO: assert property (!ramp_on |=> acc_reg == 16'h0000 && !active_reg) // RULE1
    else $error("Accumulator not cleared while slope is off.");
  AST_HYST_DATA: assert property (hyst_mode && !wr_conh && !wr_high && !wr_low |=>
    dac_reg == ($past(sel_bus.hyst_level) ? high_reg : low_reg)) // RULE7
    else $error("Hysteretic data source does not follow the selected input.");
  AST_HYST_OFF: assert property (!hyst_mode |=> !invert_reg) // RULE2
    else $error("Polarity changed outside hysteretic mode.");
  AST_POLARITY: assert property (hyst_mode && !wr_conh |=>
    invert_reg == $past(sel_bus.hyst_level)) // RULE8
    else $error("Comparator polarity does not track the hysteretic input.");
  AST_BLANK_START: assert property (hyst_mode && hyst_edge && blank_cfg_reg != 10'h000 |=>
    blank_reg && blank_cnt_reg == $past(blank_cfg_reg)) // RULE9
    else $error("Blanking not restarted on hysteretic edge.");
  AST_BLANK_LEN: assert property (hyst_mode && hyst_edge && blank_cfg_reg == 10'h005 &&
    !wr_blank ##1 !hyst_edge[*5] |=> !blank_reg) // RULE17
    else $error("Blanking lasted longer than the programmed count.");
  AST_HYST_ONE: assert property (sel_bus.hyst_code == 4'hf |-> sel_bus.hyst_level) // RULE10
    else $error("Hysteretic code 1111 did not give one.");
  AST_STOPB_ZERO: assert property (sel_bus.stop_b_code == 4'h0 |-> !sel_bus.stop_b) // RULE13
    else $error("Stop B code 0000 did not give zero.");
  AST_STOP_HOLD: assert property (ramp_on && !wr_conh && state_reg == DSH_RAMP && stop_any |=>
    state_reg == DSH_HOLD ##1 (acc_reg == $past(acc_reg) || !ramp_on)) // RULE11
    else $error("Stop did not freeze the ramp.");
  AST_STEP_UP: assert property (ramp_on && !wr_conh && !wr_rate && state_reg == DSH_RAMP &&
    dir_up_reg && !stop_any && !up_hit |=> acc_reg == $past(acc_reg) + $past(rate_reg)) // RULE19
    else $error("Upward ramp did not advance by the rate.");
  AST_START: assert property (ramp_on && !wr_conh && state_reg != DSH_RAMP && start_edge &&
    !stop_any |=> active_reg && dir_up_reg == $past(positive) &&
    acc_reg == ($past(positive) ? $past(low_fx) : $past(high_fx))) // RULE4
    else $error("Start edge did not load the ramp.");
  AST_TRI_TURN: assert property (tri_mode && !wr_conh && state_reg == DSH_RAMP && dir_up_reg &&
    up_hit && !stop_any |=> !dir_up_reg && state_reg == DSH_RAMP) // RULE3
    else $error("Triangle ramp did not reverse at the high limit.");

  // Checks on the falling ramp, the constant start and the selector codes.
  AST_STEP_DOWN: assert property (ramp_on && !wr_conh && !wr_rate && state_reg == DSH_RAMP &&
    !dir_up_reg && !stop_any && !dn_hit |=> acc_reg == $past(acc_reg) - $past(rate_reg)) // RULE19
    else $error("Downward ramp did not fall by the rate.");
  AST_CONST_START: assert property (ramp_on && !$past(ramp_on) && sel_bus.start_code == 4'hf &&
    !stop_any |=> active_reg) // RULE14
    else $error("Constant-one start did not begin a slope on enable.");
  AST_HYST_ZERO: assert property (sel_bus.hyst_code == 4'h0 |-> !sel_bus.hyst_level) // RULE10
    else $error("Hysteretic code 0000 did not give zero.");
  AST_STOPA_ONE: assert property (sel_bus.stop_a_code == 4'hf |-> sel_bus.stop_a) // RULE12
    else $error("Stop A code 1111 did not give one.");
  AST_STOPB_ONE: assert property (sel_bus.stop_b_code == 4'hf |-> sel_bus.stop_b) // RULE13
    else $error("Stop B code 1111 did not give one.");

  COV_SLOPE_STOP: cover property (state_reg == DSH_RAMP && stop_any ##1 state_reg == DSH_HOLD);
  COV_TRI_TURN: cover property (tri_mode && dir_up_reg ##1 tri_mode && !dir_up_reg);
  COV_HYST_BLANK: cover property (hyst_mode && hyst_edge ##1 blank_reg);
  COV_CONST_START: cover property (sel_bus.start_code == 4'hf && start_edge ##1 active_reg);
endmodule // dsh_slope_ctrl

//--- verilog/dsh_params.svh
// Register offsets, field positions, select codes and reset values of the slope control.
`ifndef DSH_PARAMS_SVH
`define DSH_PARAMS_SVH
`define DSH_OFS_CONH 3'h0
`define DSH_OFS_CONL 3'h1
`define DSH_OFS_RATE 3'h2
`define DSH_OFS_HIGH 3'h3
`define DSH_OFS_LOW 3'h4
`define DSH_OFS_BLANK 3'h5
`define DSH_OFS_STAT 3'h6
`define DSH_OFS_ACC 3'h7
`define DSH_BIT_RAMP_ON 15
`define DSH_BIT_HYST_ON 11
`define DSH_BIT_TRI_ON 10
`define DSH_BIT_POSITIVE 9
`define DSH_CONH_MASK 16'h8e00
`define DSH_RST_16 16'h0000
`define DSH_RST_12 12'h000
`define DSH_RST_10 10'h000
`define DSH_FRAC_ZERO 4'h0
`define DSH_CODE_ZERO 4'h0
`define DSH_CODE_ONE 4'hf
`define DSH_CODE_HYST_LAST 4'hc
`define DSH_CODE_TRIG_LAST 4'h8
`define DSH_CODE_XTRIG_A 4'hd
`define DSH_CODE_XTRIG_B 4'he
`define DSH_CODE_CMP_LAST 4'h4
`define DSH_HYST_W 12
`define DSH_TRIG_W 10
`define DSH_CMP_W 4
`define DSH_SYNC_W 36
`endif

//--- verilog/dsh_pkg.sv
// Types shared by the slope control modules.
package dsh_pkg;
  typedef enum logic [1:0] {
    DSH_IDLE = 2'b00,
    DSH_RAMP = 2'b01,
    DSH_HOLD = 2'b10
  } dsh_state_t;
endpackage

//--- verilog/dsh_sel_if.sv
// Carrier between the control core and its input selector.
`timescale 1ns/10ps
`include "dsh_params.svh"
interface dsh_sel_if;
  logic [3:0] hyst_code;
  logic [3:0] stop_a_code;
  logic [3:0] stop_b_code;
  logic [3:0] start_code;
  logic [`DSH_HYST_W-1:0] hyst_vec;
  logic [`DSH_TRIG_W-1:0] stop_a_vec;
  logic [`DSH_CMP_W-1:0] stop_b_vec;
  logic [`DSH_TRIG_W-1:0] start_vec;
  logic hyst_level;
  logic stop_a;
  logic stop_b;
  logic start_level;
  modport ctrl (output hyst_code, stop_a_code, stop_b_code, start_code, hyst_vec, stop_a_vec,
    stop_b_vec, start_vec, input hyst_level, stop_a, stop_b, start_level);
  modport sel (input hyst_code, stop_a_code, stop_b_code, start_code, hyst_vec, stop_a_vec,
    stop_b_vec, start_vec, output hyst_level, stop_a, stop_b, start_level);
endinterface

//--- verilog/dsh_source_select.sv
// Picks the hysteretic, stop and start signals by their 4-bit select codes.
`timescale 1ns/10ps
`include "dsh_params.svh"
module dsh_source_select (
  dsh_sel_if.sel sel
);
  // Trigger fields: codes 1..8 pick the own-core triggers, 13 and 14 the other core's.
  function automatic logic dsh_pick_trig(input logic [3:0] code,
                                          input logic [`DSH_TRIG_W-1:0] vec);
    logic r;
    r = 1'b0;
    if (code == `DSH_CODE_ONE) begin
      r = 1'b1;
    end else if (code != `DSH_CODE_ZERO && code <= `DSH_CODE_TRIG_LAST) begin
      r = vec[code - 4'h1];
    end else if (code == `DSH_CODE_XTRIG_A) begin
      r = vec[`DSH_TRIG_W-2];
    end else if (code == `DSH_CODE_XTRIG_B) begin
      r = vec[`DSH_TRIG_W-1];
    end
    return r;
  endfunction

  // RULE10: hysteretic code map
  assign sel.hyst_level = (sel.hyst_code == `DSH_CODE_ONE) ? 1'b1 :
    (sel.hyst_code != `DSH_CODE_ZERO && sel.hyst_code <= `DSH_CODE_HYST_LAST) ?
    sel.hyst_vec[sel.hyst_code - 4'h1] : 1'b0;
  // RULE12: stop A map
  assign sel.stop_a = dsh_pick_trig(sel.stop_a_code, sel.stop_a_vec);
  // RULE13: stop B map
  assign sel.stop_b = (sel.stop_b_code == `DSH_CODE_ONE) ? 1'b1 :
    (sel.stop_b_code != `DSH_CODE_ZERO && sel.stop_b_code <= `DSH_CODE_CMP_LAST) ?
    sel.stop_b_vec[sel.stop_b_code[1:0] - 2'h1] : 1'b0;
  // RULE14: start code map
  assign sel.start_level = dsh_pick_trig(sel.start_code, sel.start_vec);
endmodule // dsh_source_select

//--- sim/dsh_trig_model.sv
// Far-side model of the PWM trigger lines and comparator outputs.
`timescale 1ns/10ps
`include "dsh_params.svh"
module dsh_trig_model (
  input wire logic sys_clk,
  output logic [`DSH_HYST_W-1:0] hyst_src,
  output logic [`DSH_TRIG_W-1:0] stop_a_src,
  output logic [`DSH_CMP_W-1:0] stop_b_src,
  output logic [`DSH_TRIG_W-1:0] start_src
);
  // Every source idles low until the bench commands a level change.
  initial begin
    hyst_src = 12'h000;
    stop_a_src = 10'h000;
    stop_b_src = 4'h0;
    start_src = 10'h000;
  end

  // Levels move just after a rising edge and then stand, as a PWM output would.
  task put(input int unsigned grp, input int unsigned idx, input logic v);
    @(posedge sys_clk);
    case (grp)
      0: hyst_src[idx] <= v;
      1: stop_a_src[idx] <= v;
      2: stop_b_src[idx] <= v;
      default: start_src[idx] <= v;
    endcase
  endtask
endmodule // dsh_trig_model

//--- sim/test_dsh_slope_ctrl.sv
// Self-checking bench for the slope and hysteretic control.
`timescale 1ns/10ps
module test_dsh_slope_ctrl;
  localparam logic [11:0] LO = 12'h0cd;
  localparam logic [11:0] HI = 12'hf32;
  logic sys_clk, rst, reg_wr, reg_rd, cmp_invert, cmp_blank, ramp_active;
  logic [2:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rv, d1;
  logic [11:0] hyst_src, dac_data;
  logic [9:0] stop_a_src, start_src;
  logic [3:0] stop_b_src;
  logic [15:0] msk [8];
  int err_total, n_compared, cnt, c;

  dsh_slope_ctrl dsh_slope_ctrl_inst (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .hyst_src(hyst_src), .stop_a_src(stop_a_src), .stop_b_src(stop_b_src),
    .start_src(start_src), .dac_data(dac_data), .cmp_invert(cmp_invert),
    .cmp_blank(cmp_blank), .ramp_active(ramp_active));
  dsh_trig_model dsh_trig_model_inst (.sys_clk(sys_clk), .hyst_src(hyst_src),
    .stop_a_src(stop_a_src), .stop_b_src(stop_b_src), .start_src(start_src));

  // Free-running 50 ns clock.
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Register bus cycles; a write leaves one idle cycle so no strobe is set twice at once.
  task wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask

  // Comparison and verdict.
  task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task results;
    $display("Compared %0d, mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Bounded wait on the ramp flag; running out ends the run.
  task until_active(input logic v);
    int k;
    for (k = 0; k < 20 && ramp_active !== v; k++) @(negedge sys_clk);
    if (ramp_active !== v) begin
      err_total++;
      $display("MISMATCH %0t ramp flag never reached %b", $time, v);
      results();
    end
  endtask

  // Reset values, write masks and the read-only accumulator.
  task t_regs;
    msk = '{16'h8e00, 16'hffff, 16'habcd, 16'h0fff, 16'h0fff, 16'h03ff, 16'h0000, 16'h0000};
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), rv);
      chk(rv, 16'h0000, "reset value");
    end
    for (int a = 0; a < 8; a++) begin
      if (a != 6) begin
        wr(3'(a), (a == 2) ? 16'habcd : 16'hffff);
        rd(3'(a), rv);
        chk(rv, msk[a], "write mask");
      end
    end
    wr(3'h0, 16'h0000);
    $display("test regs done");
  endtask

  // Rising and falling 12.4 ramps, stop hold and enable clear.
  task t_ramp;
    wr(3'h3, {4'h0, HI});
    wr(3'h4, {4'h0, LO});
    wr(3'h2, 16'h0018);
    wr(3'h1, 16'h0021);
    wr(3'h0, 16'h8200);
    dsh_trig_model_inst.put(3, 0, 1'b1);
    until_active(1'b1);
    chk(16'(dac_data), 16'(LO), "ramp start low");
    for (int k = 1; k < 5; k++) begin
      @(negedge sys_clk);
      chk(16'(dac_data), 16'(LO + (3 * k) / 2), "ramp step");
    end
    dsh_trig_model_inst.put(2, 1, 1'b1);
    until_active(1'b0);
    d1 = 16'(dac_data);
    repeat (5) @(negedge sys_clk);
    chk(16'(dac_data), d1, "hold on stop");
    wr(3'h0, 16'h0000);
    rd(3'h7, rv);
    chk(rv, 16'h0000, "accumulator off");
    chk(16'(dac_data), 16'h0000, "dac off");
    dsh_trig_model_inst.put(3, 0, 1'b0);
    dsh_trig_model_inst.put(2, 1, 1'b0);
    wr(3'h0, 16'h8000);
    dsh_trig_model_inst.put(3, 0, 1'b1);
    until_active(1'b1);
    chk(16'(dac_data), 16'(HI), "fall start high");
    @(negedge sys_clk);
    chk(16'(dac_data), 16'(HI - 12'h002), "fall step");
    wr(3'h0, 16'h0000);
    dsh_trig_model_inst.put(3, 0, 1'b0);
    $display("test ramp done");
  endtask

  // Every input-picking start, stop A and stop B code, and the constant codes.
  task t_codes;
    for (int i = 0; i < 10; i++) begin
      c = (i < 8) ? i + 1 : i + 5;
      wr(3'h1, {4'h0, 4'(c), 4'h0, 4'(c)});
      wr(3'h0, 16'h8200);
      dsh_trig_model_inst.put(3, i, 1'b1);
      until_active(1'b1);
      dsh_trig_model_inst.put(3, i, 1'b0);
      dsh_trig_model_inst.put(1, i, 1'b1);
      until_active(1'b0);
      dsh_trig_model_inst.put(1, i, 1'b0);
      wr(3'h0, 16'h0000);
    end
    for (int j = 0; j < 4; j++) begin
      wr(3'h1, {8'h00, 4'(j + 1), 4'hf});
      wr(3'h0, 16'h8200);
      until_active(1'b1);
      dsh_trig_model_inst.put(2, j, 1'b1);
      until_active(1'b0);
      dsh_trig_model_inst.put(2, j, 1'b0);
      wr(3'h0, 16'h0000);
    end
    for (int j = 0; j < 2; j++) begin
      wr(3'h1, (j == 0) ? 16'h0f0f : 16'h00f0);
      wr(3'h0, 16'h8200);
      repeat (8) @(negedge sys_clk);
      chk(16'(ramp_active), 16'h0000, "constant stop or zero start");
      wr(3'h0, 16'h0000);
    end
    $display("test codes done");
  endtask

  // Triangle keeps moving after it meets the high limit.
  task t_tri;
    wr(3'h2, 16'h4000);
    wr(3'h1, 16'h000f);
    wr(3'h0, 16'h8600);
    repeat (20) @(negedge sys_clk);
    d1 = 16'(dac_data);
    @(negedge sys_clk);
    chk(16'(d1 !== 16'(dac_data)), 16'h0001, "triangle turns");
    chk(16'(ramp_active), 16'h0001, "triangle runs");
    wr(3'h0, 16'h0000);
    $display("test triangle done");
  endtask

  // One hysteretic input edge: limit, polarity and blanking length.
  task hyst_edge(input int i, input logic v);
    dsh_trig_model_inst.put(0, i, v);
    cnt = 0;
    repeat (12) begin
      @(negedge sys_clk);
      if (cmp_blank === 1'b1) cnt++;
    end
    chk(16'(dac_data), v ? 16'(HI) : 16'(LO), "hyst limit");
    chk(16'(cmp_invert), 16'(v), "hyst polarity");
    chk(16'(cnt), 16'h0005, "blank length");
  endtask
  task t_hyst;
    wr(3'h5, 16'h0005);
    wr(3'h0, 16'h0800);
    for (int i = 0; i < 12; i++) begin
      wr(3'h1, {4'(i + 1), 12'h000});
      hyst_edge(i, 1'b1);
      hyst_edge(i, 1'b0);
    end
    for (int j = 0; j < 2; j++) begin
      wr(3'h1, (j == 0) ? 16'hf000 : 16'h0000);
      repeat (8) @(negedge sys_clk);
      chk(16'(dac_data), (j == 0) ? 16'(HI) : 16'(LO), "hyst constant");
    end
    $display("test hysteretic done");
  endtask

  // Main sequence.
  initial begin
    rst = 1'b1;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    err_total = 0;
    n_compared = 0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_ramp();
    t_codes();
    t_tri();
    t_hyst();
    results();
  end
endmodule // test_dsh_slope_ctrl
